//--- rtl/spmw_pkg.sv
package spmw_pkg;

   // ------------------------------------------------------------
   // bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // register byte addresses
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0] ADDR_CTRL   = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_PINCFG = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_EECMD  = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_PROBE  = 8'h10;

   // ------------------------------------------------------------
   // control register fields
   // ------------------------------------------------------------
   localparam int CTRL_SLEEP_BIT    = 0;
   localparam int CTRL_WAKE_EN_BIT  = 1;
   localparam int CTRL_WAKE_POL_BIT = 2;
   localparam int CTRL_WAKE_OD_BIT  = 3;
   localparam int CTRL_W            = 3;
   localparam logic [CTRL_W-1:0] CTRL_RESET = 3'h0;

   // ------------------------------------------------------------
   // pin configuration fields
   // ------------------------------------------------------------
   localparam int PIN_DATA_MODE_LSB = 0;
   localparam int PIN_CLK_MODE_LSB  = 2;
   localparam int PIN_GENERAL_OUTPUT_THREE_BIT      = 4;
   localparam int PIN_GENERAL_OUTPUT_FOUR_BIT      = 5;
   localparam int PINCFG_W          = 6;
   localparam logic [PINCFG_W-1:0] PINCFG_RESET = 6'h00;

   // ------------------------------------------------------------
   // eeprom command fields
   // ------------------------------------------------------------
   localparam int EE_SEL_BIT   = 0;
   localparam int EE_CLK_BIT   = 1;
   localparam int EE_DOUT_BIT  = 2;
   localparam int EE_DOE_BIT   = 3;
   localparam int EE_DIN_BIT   = 4;
   localparam int EECMD_W      = 4;
   localparam logic [EECMD_W-1:0] EECMD_RESET = 4'h0;

   // ------------------------------------------------------------
   // status fields
   // ------------------------------------------------------------
   localparam int ST_STRAP_BIT    = 0;
   localparam int ST_SPEED100_BIT = 1;
   localparam int ST_FULLDUP_BIT  = 2;
   localparam int ST_AUTONEG_BIT  = 3;
   localparam int ST_ASLEEP_BIT   = 4;
   localparam int ST_WAKE_BIT     = 5;
   localparam int ST_READ_BIT     = 6;

   // ------------------------------------------------------------
   // defaults and clock
   // ------------------------------------------------------------
   localparam logic DEFAULT_FULL_DUPLEX = 1'b0;
   localparam int   REF_CLOCK_HZ        = 25_000_000;

   typedef enum logic [1:0] {
      SPMW_MODE_EEPROM,
      SPMW_MODE_GPO,
      SPMW_MODE_MON_A,
      SPMW_MODE_MON_B
   } spmw_pin_mode_t;

   typedef enum logic {
      SPMW_AWAKE,
      SPMW_ASLEEP
   } spmw_pwr_t;

endpackage

//--- rtl/spmw_pin_sel.sv
`timescale 1ns/1ns
`default_nettype none

module spmw_pin_sel (
   input  wire logic                     clock,
   input  wire logic                     rst_n,
   input  wire spmw_pkg::spmw_pin_mode_t mode,
   input  wire logic                     eeprom_val,
   input  wire logic                     eeprom_oe,
   input  wire logic                     gpo_val,
   input  wire logic                     mon_a,
   input  wire logic                     mon_b,
   output logic                          pin_r,
   output logic                          pin_oe_n_r
);

   // ------------------------------------------------------------
   // registered pin source
   // ------------------------------------------------------------
   logic pin_nxt;
   logic oe_n_nxt;

   always_comb begin
      pin_nxt  = 1'b0;
      oe_n_nxt = 1'b0;
      case (mode)
         spmw_pkg::SPMW_MODE_EEPROM: begin
            pin_nxt  = eeprom_val;
            oe_n_nxt = ~eeprom_oe;
         end
         spmw_pkg::SPMW_MODE_GPO:   pin_nxt = gpo_val;
         spmw_pkg::SPMW_MODE_MON_A: pin_nxt = mon_a;
         spmw_pkg::SPMW_MODE_MON_B: pin_nxt = mon_b;
         default:                   pin_nxt = 1'b0;
      endcase
   end

   // never an input outside eeprom mode
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pin_r      <= 1'b0;
         pin_oe_n_r <= 1'b1;
      end else begin
         pin_r      <= pin_nxt;
         pin_oe_n_r <= oe_n_nxt;
      end
   end

   a_gpo_drives: assert property (@(posedge clock) disable iff (!rst_n)
      (mode == spmw_pkg::SPMW_MODE_GPO) |=> (pin_r == $past(gpo_val) && !pin_oe_n_r))
      else $error("gpo mode not driving pin");

endmodule

`default_nettype wire

//--- rtl/spmw_ctrl.sv
// Operation
// - strap picks default speed and autonegotiation
// - strap value latched when reset releases
// - data pin eeprom, output or tx monitor
// - data pin reuse forces eeprom select off
// - clock pin eeprom, output or rx monitor
// - clock pin reuse forces eeprom select off
// - dedicated eeprom select output frames accesses
// - logic runs on the reference clock
// - reset low returns everything to reset
// - internal power-on reset when pin undriven
// - writes ignored until a read occurs
// - wake indicator, programmable polarity and drive
// - wake event alone never leaves sleep
// - only a host write cycle wakes
//
// Chosen here: strobed register access and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module spmw_ctrl #(
   parameter logic [31:0] PROBE_VALUE = 32'h5A5A_C3C3 // arbitrary value
) (
   input  wire logic                        clock,
   input  wire logic                        resetn,
   input  wire logic                        por_n,
   input  wire logic [spmw_pkg::ADDR_W-1:0] reg_addr,
   input  wire logic [spmw_pkg::DATA_W-1:0] reg_wdata,
   input  wire logic                        reg_wr,
   input  wire logic                        reg_rd,
   output logic      [spmw_pkg::DATA_W-1:0] reg_rdata,
   input  wire logic                        chip_select_pin_n,
   input  wire logic                        write_strobe_pin_n,
   input  wire logic                        speed_strap,
   output logic                             default_speed100,
   output logic                             default_full_duplex,
   output logic                             default_autoneg,
   input  wire logic                        mii_tx_en,
   input  wire logic                        mii_tx_clk,
   input  wire logic                        mii_rx_dv,
   input  wire logic                        mii_rx_clk,
   input  wire logic                        eeprom_data_pin_i,
   output logic                             eeprom_data_pin_o,
   output logic                             eeprom_data_pin_oe_n,
   output logic                             eeprom_clock_pin,
   output logic                             eeprom_select_pin,
   input  wire logic                        wake_event_in,
   output logic                             wake_indicator_pin_o,
   output logic                             wake_indicator_pin_oe_n,
   output logic                             asleep
);

   // ------------------------------------------------------------
   // reset combine
   // ------------------------------------------------------------
   logic rst_n;

   assign rst_n = resetn & por_n;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   logic                            strap_taken_r;
   logic                            strap_r;
   logic [spmw_pkg::CTRL_W-1:0]     ctrl_r;
   logic [spmw_pkg::PINCFG_W-1:0]   pincfg_r;
   logic [spmw_pkg::EECMD_W-1:0]    eecmd_r;
   logic                            read_seen_r;
   logic                            wake_flag_r;
   spmw_pkg::spmw_pwr_t             pwr_r;
   spmw_pkg::spmw_pwr_t             pwr_nxt;
   spmw_pkg::spmw_pin_mode_t        data_mode;
   spmw_pkg::spmw_pin_mode_t        clk_mode;
   logic                            host_wr_cycle;
   logic                            wr_ok;
   logic                            sleep_req;
   logic                            wake_clear;
   logic                            wake_active;
   logic                            wake_level;
   logic                            select_nxt;
   logic [spmw_pkg::DATA_W-1:0]     rdata_nxt;

   assign host_wr_cycle = ~chip_select_pin_n & ~write_strobe_pin_n;
   assign wr_ok         = reg_wr & read_seen_r & (pwr_r == spmw_pkg::SPMW_AWAKE);
   assign sleep_req     = wr_ok & (reg_addr == spmw_pkg::ADDR_CTRL)
                          & reg_wdata[spmw_pkg::CTRL_SLEEP_BIT];
   assign wake_clear    = wr_ok & (reg_addr == spmw_pkg::ADDR_STATUS)
                          & reg_wdata[spmw_pkg::ST_WAKE_BIT];
   assign data_mode     = spmw_pkg::spmw_pin_mode_t'(
                          pincfg_r[spmw_pkg::PIN_DATA_MODE_LSB +: 2]);
   assign clk_mode      = spmw_pkg::spmw_pin_mode_t'(
                          pincfg_r[spmw_pkg::PIN_CLK_MODE_LSB +: 2]);

   // ------------------------------------------------------------
   // strap capture
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         strap_taken_r       <= 1'b0;
         strap_r             <= 1'b0;
         default_speed100    <= 1'b0;
         default_full_duplex <= spmw_pkg::DEFAULT_FULL_DUPLEX;
         default_autoneg     <= 1'b0;
      end else if (!strap_taken_r) begin
         strap_taken_r       <= 1'b1;
         strap_r             <= speed_strap;
         default_speed100    <= speed_strap;
         default_full_duplex <= spmw_pkg::DEFAULT_FULL_DUPLEX;
         default_autoneg     <= speed_strap;
      end
   end

   // ------------------------------------------------------------
   // power state
   // ------------------------------------------------------------
   always_comb begin
      pwr_nxt = pwr_r;
      case (pwr_r)
         spmw_pkg::SPMW_AWAKE: begin
            if (sleep_req) begin
               pwr_nxt = spmw_pkg::SPMW_ASLEEP;
            end
         end
         spmw_pkg::SPMW_ASLEEP: begin
            if (host_wr_cycle) begin
               pwr_nxt = spmw_pkg::SPMW_AWAKE;
            end
         end
         default: pwr_nxt = spmw_pkg::SPMW_AWAKE;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pwr_r  <= spmw_pkg::SPMW_AWAKE;
         asleep <= 1'b0;
      end else begin
         pwr_r  <= pwr_nxt;
         asleep <= (pwr_nxt == spmw_pkg::SPMW_ASLEEP);
      end
   end

   // ------------------------------------------------------------
   // first read gate
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         read_seen_r <= 1'b0;
      end else if (sleep_req || pwr_r == spmw_pkg::SPMW_ASLEEP) begin
         read_seen_r <= 1'b0;
      end else if (reg_rd) begin
         read_seen_r <= 1'b1;
      end
   end

   // ------------------------------------------------------------
   // software registers
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         ctrl_r <= spmw_pkg::CTRL_RESET;
      end else if (wr_ok && reg_addr == spmw_pkg::ADDR_CTRL) begin
         ctrl_r <= reg_wdata[spmw_pkg::CTRL_WAKE_EN_BIT +: spmw_pkg::CTRL_W];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pincfg_r <= spmw_pkg::PINCFG_RESET;
      end else if (wr_ok && reg_addr == spmw_pkg::ADDR_PINCFG) begin
         pincfg_r <= reg_wdata[spmw_pkg::PINCFG_W-1:0];
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         eecmd_r <= spmw_pkg::EECMD_RESET;
      end else if (wr_ok && reg_addr == spmw_pkg::ADDR_EECMD) begin
         eecmd_r <= reg_wdata[spmw_pkg::EECMD_W-1:0];
      end
   end

   // ------------------------------------------------------------
   // wake event flag and indicator
   // ------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_flag_r <= 1'b0;
      end else if (wake_event_in) begin
         wake_flag_r <= 1'b1; // set beats clear
      end else if (wake_clear) begin
         wake_flag_r <= 1'b0;
      end
   end

   assign wake_active = ctrl_r[spmw_pkg::CTRL_WAKE_EN_BIT - spmw_pkg::CTRL_WAKE_EN_BIT]
                        & wake_flag_r;
   assign wake_level  = ctrl_r[spmw_pkg::CTRL_WAKE_POL_BIT - spmw_pkg::CTRL_WAKE_EN_BIT]
                        ? wake_active : ~wake_active;

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         wake_indicator_pin_o    <= 1'b0;
         wake_indicator_pin_oe_n <= 1'b1;
      end else if (ctrl_r[spmw_pkg::CTRL_WAKE_OD_BIT - spmw_pkg::CTRL_WAKE_EN_BIT]) begin
         wake_indicator_pin_o    <= 1'b0;
         wake_indicator_pin_oe_n <= wake_level;
      end else begin
         wake_indicator_pin_o    <= wake_level;
         wake_indicator_pin_oe_n <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // eeprom pins
   // ------------------------------------------------------------
   spmw_pin_sel u_data_pin (
      .clock      (clock),
      .rst_n      (rst_n),
      .mode       (data_mode),
      .eeprom_val (eecmd_r[spmw_pkg::EE_DOUT_BIT]),
      .eeprom_oe  (eecmd_r[spmw_pkg::EE_DOE_BIT]),
      .gpo_val    (pincfg_r[spmw_pkg::PIN_GENERAL_OUTPUT_THREE_BIT]),
      .mon_a      (mii_tx_en),
      .mon_b      (mii_tx_clk),
      .pin_r      (eeprom_data_pin_o),
      .pin_oe_n_r (eeprom_data_pin_oe_n)
   );

   spmw_pin_sel u_clock_pin (
      .clock      (clock),
      .rst_n      (rst_n),
      .mode       (clk_mode),
      .eeprom_val (eecmd_r[spmw_pkg::EE_CLK_BIT]),
      .eeprom_oe  (1'b1),
      .gpo_val    (pincfg_r[spmw_pkg::PIN_GENERAL_OUTPUT_FOUR_BIT]),
      .mon_a      (mii_rx_dv),
      .mon_b      (mii_rx_clk),
      .pin_r      (eeprom_clock_pin),
      .pin_oe_n_r ()
   );

   assign select_nxt = eecmd_r[spmw_pkg::EE_SEL_BIT]
                       & (data_mode == spmw_pkg::SPMW_MODE_EEPROM)
                       & (clk_mode == spmw_pkg::SPMW_MODE_EEPROM);

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         eeprom_select_pin <= 1'b0;
      end else begin
         eeprom_select_pin <= select_nxt;
      end
   end

   // ------------------------------------------------------------
   // read data
   // ------------------------------------------------------------
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      case (reg_addr)
         spmw_pkg::ADDR_CTRL:
            rdata_nxt[spmw_pkg::CTRL_WAKE_EN_BIT +: spmw_pkg::CTRL_W] = ctrl_r;
         spmw_pkg::ADDR_PINCFG: rdata_nxt[spmw_pkg::PINCFG_W-1:0] = pincfg_r;
         spmw_pkg::ADDR_EECMD: begin
            rdata_nxt[spmw_pkg::EECMD_W-1:0]    = eecmd_r;
            rdata_nxt[spmw_pkg::EE_DIN_BIT]     = eeprom_data_pin_i;
         end
         spmw_pkg::ADDR_STATUS: begin
            rdata_nxt[spmw_pkg::ST_STRAP_BIT]    = strap_r;
            rdata_nxt[spmw_pkg::ST_SPEED100_BIT] = default_speed100;
            rdata_nxt[spmw_pkg::ST_FULLDUP_BIT]  = default_full_duplex;
            rdata_nxt[spmw_pkg::ST_AUTONEG_BIT]  = default_autoneg;
            rdata_nxt[spmw_pkg::ST_ASLEEP_BIT]   = (pwr_r == spmw_pkg::SPMW_ASLEEP);
            rdata_nxt[spmw_pkg::ST_WAKE_BIT]     = wake_flag_r;
            rdata_nxt[spmw_pkg::ST_READ_BIT]     = read_seen_r;
         end
         spmw_pkg::ADDR_PROBE: rdata_nxt = PROBE_VALUE;
         default:              rdata_nxt = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         reg_rdata <= rdata_nxt;
      end else begin
         reg_rdata <= 32'h0000_0000;
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   a_strap_latch: assert property (@(posedge clock) disable iff (!rst_n)
      $rose(strap_taken_r) |-> (strap_r == $past(speed_strap)))
      else $error("strap not latched at reset release");

   a_strap_hold: assert property (@(posedge clock) disable iff (!rst_n)
      (strap_taken_r && $past(strap_taken_r)) |-> $stable(strap_r))
      else $error("strap changed after capture");

   a_strap_defaults: assert property (@(posedge clock) disable iff (!rst_n)
      strap_taken_r |-> (default_speed100 == strap_r && default_autoneg == strap_r
                         && !default_full_duplex))
      else $error("defaults do not follow strap");

   a_reset_state: assert property (@(posedge clock)
      !rst_n |=> (!eeprom_select_pin && !wake_flag_r && !read_seen_r && !asleep
                  && pincfg_r == spmw_pkg::PINCFG_RESET))
      else $error("reset state not reached");

   a_write_gate: assert property (@(posedge clock) disable iff (!rst_n)
      (reg_wr && !read_seen_r) |=> ($stable(pincfg_r) && $stable(ctrl_r) && $stable(eecmd_r)))
      else $error("write took effect before first read");

   a_data_select: assert property (@(posedge clock) disable iff (!rst_n)
      (data_mode != spmw_pkg::SPMW_MODE_EEPROM) |=> !eeprom_select_pin)
      else $error("select asserted while data pin reused");

   a_clock_select: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_mode != spmw_pkg::SPMW_MODE_EEPROM) |=> !eeprom_select_pin)
      else $error("select asserted while clock pin reused");

   a_select_drive: assert property (@(posedge clock) disable iff (!rst_n)
      (eecmd_r[spmw_pkg::EE_SEL_BIT] && data_mode == spmw_pkg::SPMW_MODE_EEPROM
       && clk_mode == spmw_pkg::SPMW_MODE_EEPROM) |=> eeprom_select_pin)
      else $error("select not driven for eeprom access");

   a_wake_pushpull: assert property (@(posedge clock) disable iff (!rst_n)
      (wake_active && ctrl_r[1] && !ctrl_r[2]) |=> (wake_indicator_pin_o
                                                    && !wake_indicator_pin_oe_n))
      else $error("wake indicator not asserted");

   a_sleep_stays: assert property (@(posedge clock) disable iff (!rst_n)
      (asleep && pwr_r == spmw_pkg::SPMW_ASLEEP && !host_wr_cycle) |=> asleep)
      else $error("left sleep without host write");

   a_host_wakes: assert property (@(posedge clock) disable iff (!rst_n)
      (pwr_r == spmw_pkg::SPMW_ASLEEP && host_wr_cycle) |=> (!asleep && !read_seen_r))
      else $error("host write cycle did not wake");

endmodule

`default_nettype wire

//--- testbench/spmw_ee_model.sv
`timescale 1ns/1ns
`default_nettype none

module spmw_ee_model (
   input  wire logic clock,
   input  wire logic sel,
   input  wire logic sclk,
   input  wire logic dev_o,
   input  wire logic dev_oe_n,
   output var  logic line
);
   logic reply_r = 1'b1;
   logic last_r  = 1'b0;
   logic sclk_r  = 1'b0;

   always @(posedge clock) begin
      sclk_r <= sclk;
      last_r <= line;
      if (sel && sclk && !sclk_r) begin
         reply_r <= ~reply_r;
      end
   end

   // device drive wins, selected memory answers, else no stable level
   always_comb begin
      if (!dev_oe_n) begin
         line = dev_o;
      end else if (sel) begin
         line = reply_r;
      end else begin
         line = ~last_r;
      end
   end
endmodule

`default_nettype wire

//--- testbench/spmw_ctrl_tb.sv
`timescale 1ns/1ns
`default_nettype none

module spmw_ctrl_tb;
   logic        clock  = 1'b0;
   logic        resetn = 1'b0;
   logic        por_n  = 1'b1;
   logic [7:0]  addr   = 8'h00;
   logic [31:0] wdata  = 32'h0000_0000;
   logic        wr     = 1'b0;
   logic        rd     = 1'b0;
   logic [31:0] rdata;
   logic        cs_n   = 1'b1;
   logic        ws_n   = 1'b1;
   logic        strap  = 1'b1;
   logic        wev    = 1'b0;
   logic        tx_en  = 1'b1;
   logic        tx_clk = 1'b0;
   logic        rx_dv  = 1'b1;
   logic        rx_clk = 1'b0;
   logic        spd;
   logic        fdx;
   logic        aneg;
   logic        d_o;
   logic        d_oe_n;
   logic        line;
   logic        ck_o;
   logic        sel;
   logic        wk_o;
   logic        wk_oe_n;
   logic        asleep;
   logic [31:0] d;
   int          error_cnt = 0;
   int          compares  = 0;

   always #50 clock = ~clock;

   spmw_ctrl #(.PROBE_VALUE(32'h1234_5678)) u_dut (
      .clock(clock), .resetn(resetn), .por_n(por_n), .reg_addr(addr),
      .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata),
      .chip_select_pin_n(cs_n), .write_strobe_pin_n(ws_n), .speed_strap(strap),
      .default_speed100(spd), .default_full_duplex(fdx), .default_autoneg(aneg),
      .mii_tx_en(tx_en), .mii_tx_clk(tx_clk), .mii_rx_dv(rx_dv), .mii_rx_clk(rx_clk),
      .eeprom_data_pin_i(line), .eeprom_data_pin_o(d_o),
      .eeprom_data_pin_oe_n(d_oe_n), .eeprom_clock_pin(ck_o),
      .eeprom_select_pin(sel), .wake_event_in(wev), .wake_indicator_pin_o(wk_o),
      .wake_indicator_pin_oe_n(wk_oe_n), .asleep(asleep));

   spmw_ee_model u_ee (.clock(clock), .sel(sel), .sclk(ck_o), .dev_o(d_o),
                       .dev_oe_n(d_oe_n), .line(line));

   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clock);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clock);
      wr <= 1'b0;
   endtask

   task automatic rdr(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clock);
      addr <= a;
      rd <= 1'b1;
      @(posedge clock);
      rd <= 1'b0;
      @(negedge clock);
      chk(rdata & m, e);
   endtask

   task automatic do_reset(input logic s);
      @(posedge clock);
      resetn <= 1'b0;
      strap <= s;
      repeat (6) @(posedge clock);
      resetn <= 1'b1;
      @(posedge clock);
      strap <= ~s;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic pins(input logic c, input logic w, input logic r);
      @(posedge clock);
      cs_n <= c;
      ws_n <= w;
      addr <= spmw_pkg::ADDR_PROBE;
      wr <= r;
      @(posedge clock);
      cs_n <= 1'b1;
      ws_n <= 1'b1;
      wr <= 1'b0;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic settle;
      repeat (2) @(posedge clock);
      @(negedge clock);
   endtask

   task automatic summarize;
      $display("compares=%0d error_cnt=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      do_reset(1'b1);
      chk({spd, fdx, aneg}, 3'h5);
      chk({wk_o, wk_oe_n}, 2'h2);
      rdr(spmw_pkg::ADDR_STATUS, 8'h3F, 8'h0B);
      do_reset(1'b0);
      chk({spd, fdx, aneg}, 3'h0);
      $display("strap test done");
      wrr(spmw_pkg::ADDR_PINCFG, 8'h30);
      rdr(spmw_pkg::ADDR_PINCFG, 8'hFF, 8'h00);
      wrr(spmw_pkg::ADDR_PINCFG, 8'h30);
      rdr(spmw_pkg::ADDR_PINCFG, 8'hFF, 8'h30);
      rdr(spmw_pkg::ADDR_PROBE, 32'hFFFF_FFFF, 32'h1234_5678);
      $display("write gate test done");
      wrr(spmw_pkg::ADDR_EECMD, 8'h09);
      for (int m = 0; m < 4; m++) begin
         wrr(spmw_pkg::ADDR_PINCFG, 8'h30 | 8'(m));
         settle();
         chk({sel, d_o, d_oe_n}, {m == 0, m == 1 || m == 2, 1'b0});
         wrr(spmw_pkg::ADDR_PINCFG, 8'h30 | 8'(m << 2));
         settle();
         chk({sel, ck_o}, {m == 0, m == 1 || m == 2});
      end
      wrr(spmw_pkg::ADDR_PINCFG, 8'h3A);
      tx_en <= 1'b0;
      rx_dv <= 1'b0;
      tx_clk <= 1'b1;
      rx_clk <= 1'b1;
      settle();
      chk({d_o, ck_o}, 2'h0);
      wrr(spmw_pkg::ADDR_PINCFG, 8'h3F);
      settle();
      chk({d_o, ck_o, sel}, 3'h6);
      wrr(spmw_pkg::ADDR_PINCFG, 8'h30);
      wrr(spmw_pkg::ADDR_EECMD, 8'h01);
      settle();
      chk({sel, d_oe_n}, 2'h3);
      rdr(spmw_pkg::ADDR_EECMD, 8'h10, 8'h10);
      wrr(spmw_pkg::ADDR_EECMD, 8'h0F);
      settle();
      chk({sel, ck_o, d_o, d_oe_n}, 4'hE);
      rdr(spmw_pkg::ADDR_EECMD, 8'h1F, 8'h1F);
      $display("pin mux test done");
      wrr(spmw_pkg::ADDR_CTRL, 8'h06);
      pins(1'b1, 1'b1, 1'b0);
      chk({wk_o, wk_oe_n}, 2'h0);
      @(posedge clock);
      wev <= 1'b1;
      @(posedge clock);
      wev <= 1'b0;
      settle();
      chk({wk_o, wk_oe_n}, 2'h2);
      rdr(spmw_pkg::ADDR_STATUS, 8'h20, 8'h20);
      wrr(spmw_pkg::ADDR_CTRL, 8'h0A);
      settle();
      chk({wk_o, wk_oe_n}, 2'h0);
      wrr(spmw_pkg::ADDR_STATUS, 8'h20);
      settle();
      chk(wk_oe_n, 1'b1);
      $display("wake indicator test done");
      wrr(spmw_pkg::ADDR_CTRL, 8'h01);
      settle();
      chk(asleep, 1'b1);
      @(posedge clock);
      wev <= 1'b1;
      @(posedge clock);
      wev <= 1'b0;
      settle();
      chk(asleep, 1'b1);
      pins(1'b0, 1'b1, 1'b0);
      chk(asleep, 1'b1);
      pins(1'b1, 1'b0, 1'b0);
      chk(asleep, 1'b1);
      pins(1'b0, 1'b0, 1'b1);
      chk(asleep, 1'b0);
      wrr(spmw_pkg::ADDR_PINCFG, 8'h31);
      rdr(spmw_pkg::ADDR_PINCFG, 8'hFF, 8'h30);
      $display("sleep test done");
      wrr(spmw_pkg::ADDR_PINCFG, 8'h31);
      do_reset(1'b1);
      chk({sel, d_oe_n, asleep}, 3'h2);
      rdr(spmw_pkg::ADDR_PINCFG, 8'hFF, 8'h00);
      wrr(spmw_pkg::ADDR_PINCFG, 8'h31);
      @(posedge clock);
      por_n <= 1'b0;
      repeat (3) @(posedge clock);
      por_n <= 1'b1;
      rdr(spmw_pkg::ADDR_PINCFG, 8'hFF, 8'h00);
      $display("reset test done");
      summarize();
   end

   initial begin
      #(3000 * 100);
      error_cnt++;
      summarize();
   end
endmodule

`default_nettype wire
